// File: lamp_switch_spi_map.vh
// Register addresses, field positions, reset values and command-word layout
// for the lamp switch serial configuration block. Definitions only.
`ifndef LAMP_SWITCH_SPI_MAP_VH
`define LAMP_SWITCH_SPI_MAP_VH

// Five-bit register addresses (word bits 14:10, low three bits for per-output)
`define ADDR_READBACK_SEL   3'h0
`define ADDR_PULSE          3'h1
`define ADDR_SWITCH_CFG     3'h2
`define ADDR_FAULT_CFG      3'h3
`define ADDR_OVERCURRENT    3'h4
`define ADDR_GLOBAL_CFG     5'h05
`define ADDR_OSC_CAL        5'h07

// Command word fields
`define WORD_BITS           16
`define FLD_WDOG            15
`define FLD_ADDR_HI         14
`define FLD_ADDR_LO         10
`define FLD_OUT_HI          14
`define FLD_OUT_LO          13
`define FLD_REG_HI          12
`define FLD_REG_LO          10

// Overcurrent profile fields
`define OCP_XENON_DIS       8
`define OCP_COOL_HI         7
`define OCP_COOL_LO         6
`define OCP_INRUSH_HI       5
`define OCP_INRUSH_LO       4
`define OCP_HI_SWAP         3
`define OCP_STEADY_HI       2
`define OCP_STEADY_LO       1
`define OCP_MODE            0

// Global configuration fields
`define GCFG_FAIL_DET_EN    8
`define GCFG_PWM_EN         7
`define GCFG_CLK_SEL        6
`define GCFG_TEMP_EN        5
`define GCFG_FB_EN          4
`define GCFG_FB_OUT_HI      3
`define GCFG_FB_OUT_LO      2
`define GCFG_OVERVOLTAGE_PROTECT_DISABLE         0

// Reset values
`define RST_REG9            9'h000
`define RST_WORD            16'h0000
`define RST_SEL             5'h00
`define RST_COUNT           4'h0

// Feedback pin modes
`define FB_OFF              2'h0
`define FB_CURRENT          2'h1
`define FB_TEMP             2'h2

`endif

// File: lamp_switch_spi_config.v
// Serial configuration registers of a four-channel lamp switch: overcurrent
// profile per output, global configuration, calibration, readback selection.
// Assumes chip select, serial clock and serial in arrive asynchronously and
// are oversampled by sys_clk; serial clock must be well below sys_clk / 4.
// A frame that is not a whole number of words changes no register and no readback selection.
// Functional notes
// - Overcurrent profile write goes only to the output chosen by word bits 14:13.
// - Profile bit 8 set disables xenon overcurrent profile for that output.
// - Profile bits 7:6 pick cooling curve: medium, slow, fast, medium.
// - Profile bits 5:4 pick inrush curve: slow, fast, medium, very slow.
// - Profile bit 3 swaps in second high threshold during first window.
// - Profile bits 2:1 pick steady limit: level two, three, four, one.
// - Profile bit 0 adds cooling management to inrush management.
// - Global bit 8 enables supply-fail detector and fail-safe pulse-driven outputs.
// - Global bit 7 drives outputs from pulse registers, ignoring direct inputs.
// - Global bit 6 picks pulse clock source when pulse module enabled.
// - Global bits 5:4 set feedback pin: off, current copy, temperature.
// - Global bits 3:2 choose which output current is copied.
// - Global bit 0 set disables overvoltage protection.
// - Chip select fall loads output word, shifted out MSB first.
// - First sixteen output bits: bit 15 of previous valid command, selection, a one, selected data.
// - Bits beyond sixteen echo bits shifted in since chip select fell.
// - Chip select rise latches data only if bit count is multiple of sixteen.
// - After valid frame serial out floats and fault status accepts news.
// - Low five bits of last readback command choose returned register.
// - Upper two select bits choose output for per-output registers.
// - Readback selection persists until another readback command.
// - Invalid-length frame leaves selection and registers untouched.
// - Address is word bits 14:10; codes 00 to 11 select outputs 0 to 3.
`timescale 1ns/1ps
`include "lamp_switch_spi_map.vh"

module lamp_switch_spi_config #(
    parameter REG_W = 9,
    parameter OUTS  = 4
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             nrst,
    // Serial link from the master
    input  wire             chipSelectLow,
    input  wire             serialClk,
    input  wire             serialIn,
    output reg              serialOut,
    output reg              serialOutEnableLow,
    // Status fed into readback
    input  wire [7:0]       faultStatus0,
    input  wire [7:0]       faultStatus1,
    input  wire [7:0]       faultStatus2,
    input  wire [7:0]       faultStatus3,
    input  wire             powerOnSeen,
    // Frame outcome
    output reg              faultAccept,
    // Overcurrent profile fields, one slice per output
    output reg  [OUTS-1:0]  xenonProfileDisable,
    output reg  [2*OUTS-1:0] coolingCurve,
    output reg  [2*OUTS-1:0] inrushCurve,
    output reg  [OUTS-1:0]  highThresholdSwap,
    output reg  [2*OUTS-1:0] steadyLimit,
    output reg  [OUTS-1:0]  overcurrentModeSelect,
    // Global configuration
    output reg              supplyFailDetectEnable,
    output reg              pulseModuleEnable,
    output reg              pulseClockInternal,
    output reg  [1:0]       feedbackMode,
    output reg  [1:0]       feedbackOutputSelect,
    output reg              overvoltageProtectDisable,
    output reg  [REG_W-1:0] oscillatorCalibration
);

    // Link pins are asynchronous: two flops each before any logic reads them
    // Edge detectors start at the idle pin levels, so reset makes no false edge
    reg [1:0] csSync;
    reg [1:0] sckSync;
    reg [1:0] siSync;
    reg       csPrev;
    reg       sckPrev;

    always @(posedge sys_clk) begin
        if (!nrst) begin
            csSync  <= 2'h3;
            sckSync <= 2'h0;
            siSync  <= 2'h0;
            csPrev  <= 1'b1;
            sckPrev <= 1'b0;
        end else begin
            csSync  <= {csSync[0], chipSelectLow};
            sckSync <= {sckSync[0], serialClk};
            siSync  <= {siSync[0], serialIn};
            csPrev  <= csSync[1];
            sckPrev <= sckSync[1];
        end
    end

    wire csFall  = csPrev & ~csSync[1];
    wire csRise  = ~csPrev & csSync[1];
    wire active  = ~csSync[1];
    wire sckRise = active & ~sckPrev & sckSync[1];
    wire sckFall = active & sckPrev & ~sckSync[1];

    // Register storage
    reg [REG_W-1:0] ocProfile [0:OUTS-1];
    reg [REG_W-1:0] pulseReg  [0:OUTS-1];
    reg [REG_W-1:0] switchCfg [0:OUTS-1];
    reg [REG_W-1:0] faultCfg  [0:OUTS-1];
    reg [REG_W-1:0] globalCfg;
    reg [4:0]       readSel;
    reg [`WORD_BITS-1:0] lastWord;

    // Shift state
    reg [`WORD_BITS-1:0] rxShift;
    reg [`WORD_BITS-1:0] txShift;
    reg [3:0]            bitCount;
    reg                  gotBits;

    // Output word built from previous valid command and current selection
    wire [1:0] selOut = readSel[4:3];
    reg  [7:0] selFault;
    reg  [8:0] selData;

    always @* begin
        case (selOut)
            2'h0:    selFault = faultStatus0;
            2'h1:    selFault = faultStatus1;
            2'h2:    selFault = faultStatus2;
            default: selFault = faultStatus3;
        endcase

        case (readSel[2:0])
            `ADDR_READBACK_SEL: selData = {powerOnSeen, selFault};
            `ADDR_PULSE:        selData = pulseReg[selOut];
            `ADDR_SWITCH_CFG:   selData = switchCfg[selOut];
            `ADDR_FAULT_CFG:    selData = faultCfg[selOut];
            `ADDR_OVERCURRENT:  selData = ocProfile[selOut];
            // Global and calibration exist once; other output codes read back zero
            default: begin
                if (readSel == `ADDR_GLOBAL_CFG)
                    selData = globalCfg;
                else if (readSel == `ADDR_OSC_CAL)
                    selData = oscillatorCalibration;
                else
                    selData = 9'h000;
            end
        endcase
    end

    // Bit 9 of the reply always reads one in normal operation
    wire [`WORD_BITS-1:0] replyWord = {lastWord[`FLD_WDOG], readSel, 1'b1, selData};

    // Decode of the received word
    // Only the last sixteen bits of a longer frame are decoded
    wire [4:0]       rxAddr = rxShift[`FLD_ADDR_HI:`FLD_ADDR_LO];
    wire [1:0]       rxOut  = rxShift[`FLD_OUT_HI:`FLD_OUT_LO];
    wire [2:0]       rxReg  = rxShift[`FLD_REG_HI:`FLD_REG_LO];
    wire [REG_W-1:0] rxData = rxShift[REG_W-1:0];
    wire             frameOk = gotBits & (bitCount == 4'h0);

    // Write strobes per register kind; only a whole-word frame end raises them
    wire frameEnd = csRise & frameOk;
    wire wrSelect = frameEnd & (rxReg == `ADDR_READBACK_SEL);
    wire wrPulse  = frameEnd & (rxReg == `ADDR_PULSE);
    wire wrSwitch = frameEnd & (rxReg == `ADDR_SWITCH_CFG);
    wire wrFault  = frameEnd & (rxReg == `ADDR_FAULT_CFG);
    wire wrProf   = frameEnd & (rxReg == `ADDR_OVERCURRENT);
    wire wrGlobal = frameEnd & (rxAddr == `ADDR_GLOBAL_CFG);
    wire wrOscCal = frameEnd & (rxAddr == `ADDR_OSC_CAL);

    integer i;

    // Link side: shift registers, bit count and the serial output pin
    always @(posedge sys_clk) begin
        if (!nrst) begin
            rxShift            <= `RST_WORD;
            txShift            <= `RST_WORD;
            bitCount           <= `RST_COUNT;
            gotBits            <= 1'b0;
            serialOut          <= 1'b0;
            serialOutEnableLow <= 1'b1;
            faultAccept        <= 1'b0;
        end else begin
            faultAccept <= frameEnd;
            if (csFall) begin
                // Reply is frozen here, so status moving mid-frame cannot tear it
                txShift            <= replyWord;
                serialOut          <= replyWord[`WORD_BITS-1];
                serialOutEnableLow <= 1'b0;
                bitCount           <= `RST_COUNT;
                gotBits            <= 1'b0;
            end else if (sckRise) begin
                rxShift  <= {rxShift[`WORD_BITS-2:0], siSync[1]};
                bitCount <= bitCount + 4'h1;
                gotBits  <= 1'b1;
            end else if (sckFall) begin
                // Echo the bit taken at the rising edge; the pin may already hold the next one
                txShift   <= {txShift[`WORD_BITS-2:0], rxShift[0]};
                serialOut <= txShift[`WORD_BITS-2];
            end else if (csRise) begin
                // Any frame end floats the pin, even one of a bad length
                serialOutEnableLow <= 1'b1;
            end
        end
    end

    // Register side: storage and readback selection
    always @(posedge sys_clk) begin
        if (!nrst) begin
            for (i = 0; i < OUTS; i = i + 1) begin
                ocProfile[i] <= `RST_REG9;
                pulseReg[i]  <= `RST_REG9;
                switchCfg[i] <= `RST_REG9;
                faultCfg[i]  <= `RST_REG9;
            end
            globalCfg             <= `RST_REG9;
            oscillatorCalibration <= `RST_REG9;
            readSel               <= `RST_SEL;
            lastWord              <= `RST_WORD;
        end else begin
            // A bad-length frame raises no strobe, so the reply stays as before
            if (frameEnd)
                lastWord <= rxShift;
            if (wrSelect)
                readSel <= rxShift[4:0];
            if (wrPulse)
                pulseReg[rxOut] <= rxData;
            if (wrSwitch)
                switchCfg[rxOut] <= rxData;
            if (wrFault)
                faultCfg[rxOut] <= rxData;
            if (wrProf)
                ocProfile[rxOut] <= rxData;
            if (wrGlobal)
                globalCfg <= rxData;
            if (wrOscCal)
                oscillatorCalibration <= rxData;
        end
    end

    // Per-output profile fields gathered into flat vectors
    wire [OUTS-1:0]   next_xenonProfileDisable;
    wire [2*OUTS-1:0] next_coolingCurve;
    wire [2*OUTS-1:0] next_inrushCurve;
    wire [OUTS-1:0]   next_highThresholdSwap;
    wire [2*OUTS-1:0] next_steadyLimit;
    wire [OUTS-1:0]   next_overcurrentModeSelect;

    genvar g;

    generate
        for (g = 0; g < OUTS; g = g + 1) begin : g_profile
            assign next_xenonProfileDisable[g]   = ocProfile[g][`OCP_XENON_DIS];
            assign next_coolingCurve[2*g+:2]     = ocProfile[g][`OCP_COOL_HI:`OCP_COOL_LO];
            assign next_inrushCurve[2*g+:2]      = ocProfile[g][`OCP_INRUSH_HI:`OCP_INRUSH_LO];
            assign next_highThresholdSwap[g]     = ocProfile[g][`OCP_HI_SWAP];
            assign next_steadyLimit[2*g+:2]      = ocProfile[g][`OCP_STEADY_HI:`OCP_STEADY_LO];
            assign next_overcurrentModeSelect[g] = ocProfile[g][`OCP_MODE];
        end
    endgenerate

    // Field outputs registered from the storage
    // One cycle behind the stored value, so every output comes from a flop
    reg [1:0] fbMode;

    always @* begin
        // Current copy wins when both feedback bits are set
        if (globalCfg[`GCFG_FB_EN])
            fbMode = `FB_CURRENT;
        else if (globalCfg[`GCFG_TEMP_EN])
            fbMode = `FB_TEMP;
        else
            fbMode = `FB_OFF;
    end

    always @(posedge sys_clk) begin
        if (!nrst) begin
            xenonProfileDisable       <= {OUTS{1'b0}};
            coolingCurve              <= {2*OUTS{1'b0}};
            inrushCurve               <= {2*OUTS{1'b0}};
            highThresholdSwap         <= {OUTS{1'b0}};
            steadyLimit               <= {2*OUTS{1'b0}};
            overcurrentModeSelect     <= {OUTS{1'b0}};
            supplyFailDetectEnable    <= 1'b0;
            pulseModuleEnable         <= 1'b0;
            pulseClockInternal        <= 1'b0;
            feedbackMode              <= `FB_OFF;
            feedbackOutputSelect      <= 2'h0;
            overvoltageProtectDisable <= 1'b0;
        end else begin
            xenonProfileDisable       <= next_xenonProfileDisable;
            coolingCurve              <= next_coolingCurve;
            inrushCurve               <= next_inrushCurve;
            highThresholdSwap         <= next_highThresholdSwap;
            steadyLimit               <= next_steadyLimit;
            overcurrentModeSelect     <= next_overcurrentModeSelect;
            supplyFailDetectEnable    <= globalCfg[`GCFG_FAIL_DET_EN];
            pulseModuleEnable         <= globalCfg[`GCFG_PWM_EN];
            // Clock choice is meaningless with the module off, so it is masked
            pulseClockInternal        <= globalCfg[`GCFG_PWM_EN] & globalCfg[`GCFG_CLK_SEL];
            feedbackMode              <= fbMode;
            feedbackOutputSelect      <= globalCfg[`GCFG_FB_OUT_HI:`GCFG_FB_OUT_LO];
            overvoltageProtectDisable <= globalCfg[`GCFG_OVERVOLTAGE_PROTECT_DISABLE];
        end
    end

endmodule // lamp_switch_spi_config

// File: lamp_switch_spi_config_checker.sv
// Port-level checks of the lamp switch serial configuration block.
// Assumes a bind from the bench top; sees only design ports.
`timescale 1ns/1ps
module lamp_switch_spi_config_checker #(
    parameter OUTS = 4
) (
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              nrst,
    // Link and frame outcome
    input wire logic              chipSelectLow,
    input wire logic              serialOutEnableLow,
    input wire logic              faultAccept,
    // Fields
    input wire logic [2*OUTS-1:0] coolingCurve,
    input wire logic [2*OUTS-1:0] steadyLimit,
    input wire logic              pulseModuleEnable,
    input wire logic              pulseClockInternal,
    input wire logic [1:0]        feedbackMode
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_drive; $fell(chipSelectLow) |-> ##[1:6] !serialOutEnableLow; endproperty
    a_drive: assert property (p_drive) else $error("output not driven in frame");
    property p_float; $rose(chipSelectLow) |-> ##[1:6] serialOutEnableLow; endproperty
    a_float: assert property (p_float) else $error("output not released");
    property p_idle; chipSelectLow [*8] |-> serialOutEnableLow; endproperty
    a_idle: assert property (p_idle) else $error("output driven between frames");
    property p_pulse; faultAccept |=> !faultAccept; endproperty
    a_pulse: assert property (p_pulse) else $error("accept pulse too long");
    property p_accept; faultAccept |-> chipSelectLow; endproperty
    a_accept: assert property (p_accept) else $error("accept inside frame");
    // Fields may only move just after an accepted frame
    property p_prof;
        !$stable({coolingCurve, steadyLimit}) |-> $past(faultAccept) || $past(faultAccept, 2) || $past(faultAccept, 3);
    endproperty
    a_prof: assert property (p_prof) else $error("profile changed without frame");
    property p_gcfg;
        !$stable({pulseModuleEnable, feedbackMode}) |-> $past(faultAccept) || $past(faultAccept, 2) || $past(faultAccept, 3);
    endproperty
    a_gcfg: assert property (p_gcfg) else $error("global changed without frame");
    property p_clk; pulseClockInternal |-> pulseModuleEnable; endproperty
    a_clk: assert property (p_clk) else $error("clock select without module");
    property p_fb; feedbackMode != 2'h3; endproperty
    a_fb: assert property (p_fb) else $error("bad feedback mode");
    c_accept: cover property (faultAccept);
    c_clk: cover property ($rose(pulseClockInternal));
    c_temp: cover property (feedbackMode == 2'h2);
endmodule // lamp_switch_spi_config_checker

// File: spi_master_model.sv
// Serial master standing in for the microcontroller on the link.
// Assumes the bench calls xfer; changes pins just after rising sys_clk.
`timescale 1ns/1ps
module spi_master_model (
    // Clock
    input wire logic sys_clk,
    // Link
    output logic     chipSelectLow,
    output logic     serialClk,
    output logic     serialIn,
    input wire logic serialOut
);
    initial begin
        chipSelectLow = 1'b1;
        serialClk = 1'b0;
        serialIn = 1'b0;
    end
    // Half period of four sys_clk gives the 64 ns link clock
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = '0;
        @(posedge sys_clk) chipSelectLow <= 1'b0;
        repeat (6) @(posedge sys_clk);
        for (int i = n - 1; i >= 0; i--) begin
            serialIn <= tx[i];
            repeat (4) @(posedge sys_clk);
            serialClk <= 1'b1;
            repeat (3) @(posedge sys_clk);
            @(negedge sys_clk) rx[i] = serialOut;
            @(posedge sys_clk) serialClk <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
        chipSelectLow <= 1'b1;
        serialIn <= ~serialIn; // Released line must not keep the last bit
        repeat (8) @(posedge sys_clk);
    endtask
endmodule // spi_master_model

// File: test_lamp_switch_spi_config.sv
// Bench for the lamp switch serial configuration block.
// Assumes the master model and checker are compiled first.
`timescale 1ns/1ps
module test_lamp_switch_spi_config;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] fs [4] = '{8'h3c, 8'h5a, 8'ha5, 8'hc3};
    logic powerOnSeen = 1'b1;
    wire chipSelectLow, serialClk, serialIn, serialOut, serialOutEnableLow, faultAccept;
    wire [3:0] xenonProfileDisable, highThresholdSwap, overcurrentModeSelect;
    wire [7:0] coolingCurve, inrushCurve, steadyLimit;
    wire supplyFailDetectEnable, pulseModuleEnable, pulseClockInternal, overvoltageProtectDisable;
    wire [1:0] feedbackMode, feedbackOutputSelect;
    wire [8:0] oscillatorCalibration;
    int fails = 0;
    int n_tests = 0;
    logic [31:0] rx;
    logic [8:0] prof [4];
    always #4 sys_clk = ~sys_clk;
    spi_master_model u_spi_master_model (.sys_clk, .chipSelectLow, .serialClk, .serialIn, .serialOut);
    lamp_switch_spi_config u_lamp_switch_spi_config (.sys_clk, .nrst, .chipSelectLow, .serialClk, .serialIn,
        .serialOut, .serialOutEnableLow, .faultStatus0(fs[0]), .faultStatus1(fs[1]), .faultStatus2(fs[2]),
        .faultStatus3(fs[3]), .powerOnSeen, .faultAccept, .xenonProfileDisable, .coolingCurve, .inrushCurve,
        .highThresholdSwap, .steadyLimit, .overcurrentModeSelect, .supplyFailDetectEnable, .pulseModuleEnable,
        .pulseClockInternal, .feedbackMode, .feedbackOutputSelect, .overvoltageProtectDisable,
        .oscillatorCalibration);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("Checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic send(input logic [15:0] w);
        u_spi_master_model.xfer({16'h0, w}, 16, rx);
    endtask
    function automatic logic [15:0] rb(input int o, input logic [2:0] c);
        return {1'b0, o[1:0], 8'h0, o[1:0], c};
    endfunction
    task automatic rd(input int o, input logic [2:0] c, input logic [8:0] exp, input string what);
        send(rb(o, c));
        send(rb(o, c));
        chk(what, {1'b0, o[1:0], c, 1'b1, exp}, rx);
    endtask
    initial begin
        #400000;
        fails++;
        finish_test;
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk("reset", 0, {xenonProfileDisable, coolingCurve, inrushCurve, steadyLimit, feedbackMode});
        $display("reset test done");
        for (int o = 0; o < 4; o++) begin
            prof[o] = {o[0], o[1:0], ~o[1:0], o[1], o[1:0], ~o[0]};
            send({1'b0, o[1:0], 3'h4, 1'b0, prof[o]});
        end
        for (int o = 0; o < 4; o++) begin
            chk("xenon", prof[o][8], xenonProfileDisable[o]);
            chk("cool", prof[o][7:6], coolingCurve[2*o+:2]);
            chk("inrush", prof[o][5:4], inrushCurve[2*o+:2]);
            chk("swap", prof[o][3], highThresholdSwap[o]);
            chk("steady", prof[o][2:1], steadyLimit[2*o+:2]);
            chk("mode", prof[o][0], overcurrentModeSelect[o]);
        end
        $display("profile test done");
        for (int o = 0; o < 4; o++) begin
            send(rb(o, 3'h4));
            send(rb(o, 3'h0));
            chk("prof read", {1'b0, o[1:0], 3'h4, 1'b1, prof[o]}, rx);
            send({1'b1, 5'h07, 1'b0, 9'h0d5});
            chk("status read", {1'b0, o[1:0], 3'h0, 1'b1, powerOnSeen, fs[o]}, rx);
        end
        // Only bit 15 of the calibration write leaks into the reply
        send({1'b1, 5'h07, 1'b0, 9'h0d5});
        chk("keep sel", {1'b1, 5'h18, 1'b1, powerOnSeen, fs[3]}, rx);
        chk("cal", 9'h0d5, oscillatorCalibration);
        $display("readback test done");
        u_spi_master_model.xfer({12'h0, 1'b0, 5'h04, 1'b0, 9'h1ff, 4'h0}, 20, rx);
        chk("bad len", {prof[3][7:6], prof[2][7:6], prof[1][7:6], prof[0][7:6]}, coolingCurve);
        send({1'b0, 5'h05, 1'b0, 9'h1dd});
        chk("bad len sel", {1'b1, 5'h18, 1'b1, powerOnSeen, fs[3]}, rx);
        chk("fail det", 1'b1, supplyFailDetectEnable);
        chk("pulse en", 1'b1, pulseModuleEnable);
        chk("clk int", 1'b1, pulseClockInternal);
        chk("fb mode", 2'h1, feedbackMode);
        chk("fb out", 2'h3, feedbackOutputSelect);
        chk("overvoltage_protect_disable", 1'b1, overvoltageProtectDisable);
        $display("global test done");
        u_spi_master_model.xfer({rb(2, 3'h4), 1'b0, 5'h05, 1'b0, 9'h060}, 32, rx);
        chk("echo", rb(2, 3'h4), rx[15:0]);
        chk("first word", {1'b0, 5'h18, 1'b1, powerOnSeen, fs[3]}, rx[31:16]);
        chk("clk ext", 1'b0, pulseClockInternal);
        chk("fb temp", 2'h2, feedbackMode);
        $display("chain test done");
        send({1'b0, 2'h1, 3'h1, 1'b0, 9'h0a5});
        send({1'b0, 2'h1, 3'h2, 1'b0, 9'h03a});
        send({1'b0, 2'h1, 3'h3, 1'b0, 9'h14c});
        rd(1, 3'h1, 9'h0a5, "pulse read");
        rd(1, 3'h2, 9'h03a, "switch read");
        rd(1, 3'h3, 9'h14c, "fault cfg read");
        rd(2, 3'h1, 9'h000, "pulse other");
        rd(0, 3'h5, 9'h060, "global read");
        rd(1, 3'h5, 9'h000, "global out1");
        rd(0, 3'h7, 9'h0d5, "cal read");
        $display("register readback test done");
        nrst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk("rst fields", 0, {coolingCurve, inrushCurve, pulseModuleEnable, feedbackMode, oscillatorCalibration});
        send(rb(3, 3'h4));
        chk("rst reply", {1'b0, 5'h00, 1'b1, powerOnSeen, fs[0]}, rx);
        rd(3, 3'h4, 9'h000, "rst prof");
        rd(1, 3'h1, 9'h000, "rst pulse");
        $display("mid reset test done");
        finish_test;
    end
endmodule // test_lamp_switch_spi_config
bind lamp_switch_spi_config lamp_switch_spi_config_checker #(.OUTS(OUTS)) u_lamp_switch_spi_config_checker (
    .sys_clk, .nrst, .chipSelectLow, .serialOutEnableLow, .faultAccept, .coolingCurve, .steadyLimit,
    .pulseModuleEnable, .pulseClockInternal, .feedbackMode);
